// ### hdl/oti_pkg.sv
package oti_pkg;
  // bus widths and tributary count
  localparam int DATA_W = 8;
  localparam int NIB_W = 4;
  localparam int TRIB_N = 3;
  localparam int FIFO_DEPTH = 16;

  // field positions inside one buffered byte word
  localparam int F_DATA_LSB = 0;
  localparam int F_ALARM = 8;
  localparam int F_IDLE = 9;
  localparam int F_TOH = 10;
  localparam int F_KIND_LSB = 11;
  localparam int F_TU3 = 15;
  localparam int F_TRIB_LSB = 16;
  localparam int F_H4 = 18;
  localparam int F_FRAME = 19;
  localparam int WORD_W = 20;

  // overhead byte kinds carried with each byte
  localparam logic [3:0] POH_NONE = 4'h0;
  localparam logic [3:0] POH_J1 = 4'h1;
  localparam logic [3:0] POH_Z5 = 4'h9;
  localparam logic [3:0] POH_V5 = 4'ha;
  localparam logic [3:0] POH_Z7 = 4'hd;

  // multiframe timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int FRAME_US = 125;
  localparam int LOSS_MS = 1;
  localparam int LOSS_FRAMES = (LOSS_MS * 1000) / FRAME_US;
  localparam logic [3:0] MISS_LAST = 4'(LOSS_FRAMES - 1);
  localparam logic [2:0] SEQ_FRAMES = 3'h4;

  // values after reset
  localparam logic [7:0] BUS_RST = 8'h00;
  localparam logic [2:0] LOM_RST = 3'h7;

  // multiframe tracker states, gray along hunt, run, sync
  typedef enum logic [1:0] {
    MF_HUNT = 2'h0,
    MF_RUN = 2'h1,
    MF_SYNC = 2'h3
  } oti_mf_state_t;
endpackage

// ### hdl/oti_fifo.sv
`timescale 1ns/1ps
module oti_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 16
) (
  // system
  input wire logic clk_sys,
  input wire logic rst_b,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH]; // flop storage
  logic [PW-1:0] wr_reg;
  logic [PW-1:0] rd_reg;
  logic [CW-1:0] cnt_reg;
  logic push;
  logic pull;

  // full and empty come straight from the count
  assign in_ready = (cnt_reg != CW'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign push = in_valid & in_ready;
  assign pull = out_valid & out_ready;
  assign out_data = mem[rd_reg];

  // storage has no reset, only the pointers and the count do
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end

  // pointers wrap naturally, depth must be a power of two
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= push ? PW'(wr_reg + 1'b1) : wr_reg;
      rd_reg <= pull ? PW'(rd_reg + 1'b1) : rd_reg;
      cnt_reg <= CW'(cnt_reg + CW'(push) - CW'(pull));
    end
  end
endmodule // oti_fifo

// ### hdl/oti_mf_track.sv
`timescale 1ns/1ps
module oti_mf_track (
  // system
  input wire logic clk_sys,
  input wire logic rst_b,
  // events from the outgoing byte stream
  input wire logic frame_tick,
  input wire logic h4_strobe,
  input wire logic [1:0] h4_phase,
  // status
  output logic lost
);
  oti_pkg::oti_mf_state_t state_reg;
  oti_pkg::oti_mf_state_t state_next;
  logic [1:0] prev_reg; // last h4 phase seen
  logic [2:0] run_reg; // frames in a row in sequence
  logic [3:0] miss_reg; // frames since last good run
  logic seq_ok;
  logic acquire;
  logic timeout;

  // phase must step by one each frame
  assign seq_ok = (h4_phase == 2'(prev_reg + 2'h1));
  // fourth frame in a row completes the sequence
  // hunting never acquires: the run must restart from a first frame
  assign acquire = h4_strobe & seq_ok & (state_reg != oti_pkg::MF_HUNT) &
                   (run_reg >= 3'(oti_pkg::SEQ_FRAMES - 3'h1)); // [R9]
  // eight frames without a full sequence is one millisecond
  assign timeout = frame_tick & ~acquire &
                   (miss_reg == oti_pkg::MISS_LAST); // [R10] [R15]
  assign lost = (state_reg != oti_pkg::MF_SYNC);

  // tracker state walk
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      oti_pkg::MF_HUNT: begin
        if (h4_strobe) begin
          state_next = oti_pkg::MF_RUN;
        end
      end
      oti_pkg::MF_RUN: begin
        if (acquire) begin
          state_next = oti_pkg::MF_SYNC; // [R9]
        end else if (timeout) begin
          state_next = oti_pkg::MF_HUNT;
        end
      end
      oti_pkg::MF_SYNC: begin
        if (timeout) begin
          state_next = oti_pkg::MF_HUNT; // [R10]
        end
      end
      default: state_next = oti_pkg::MF_HUNT;
    endcase
  end

  // counters; a good run restarts the loss window
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= oti_pkg::MF_HUNT;
      prev_reg <= 2'h0;
      run_reg <= 3'h0;
      miss_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      if (h4_strobe) begin
        prev_reg <= h4_phase;
        // a run left over from a lost sync must not shorten the next one
        if (!seq_ok || (state_reg == oti_pkg::MF_HUNT)) begin
          run_reg <= 3'h1;
        end else if (run_reg < oti_pkg::SEQ_FRAMES) begin
          run_reg <= 3'(run_reg + 3'h1);
        end
      end
      if (acquire || timeout) begin
        miss_reg <= 4'h0;
      end else if (frame_tick) begin
        miss_reg <= 4'(miss_reg + 4'h1);
      end
    end
  end

  // sync is only ever entered on a fourth good frame
  chk_mf_acquire: assert property ( // [R9]
    @(posedge clk_sys) disable iff (!rst_b)
    $rose(state_reg == oti_pkg::MF_SYNC) |->
      $past(h4_strobe) && ($past(run_reg) == 3'h3))
    else $error("sync entered without four frame run");

  // eighth empty frame drops sync
  chk_mf_timeout: assert property ( // [R10]
    @(posedge clk_sys) disable iff (!rst_b)
    frame_tick && !acquire && (miss_reg == 4'h7) |=> lost)
    else $error("loss not flagged after eight frames");
endmodule // oti_mf_track

// ### hdl/oti_out_ind.sv
`timescale 1ns/1ps
// Function
// R1: alarm indicator high on alarm-inserted tributary bytes
// R2: idle indicator high on idle-coded tributary bytes
// R3: floating mode overhead values are don't-care downstream
// R4: locked mode forces indicators low on overhead
// R5: tu3 stream marks j1 through z5 bytes
// R6: other streams mark v5 j2 z6 z7
// R7: byte mode updates on byte clock rise
// R8: nibble mode updates on nibble clock rise
// R9: loss flag clears after four good frames
// R10: loss flag sets after one millisecond unsynced
// R11: top loss bit reports first tributary
// R12: loss flags change only on byte clock
// R13: nibble mode high nibble first, upper low
// R14: floating select low means locked mode
// R15: one millisecond counted as eight frames
module oti_out_ind (
  // system
  input wire logic clk_sys,
  input wire logic rst_b,
  // static configuration
  input wire logic byte_interface_select,
  input wire logic floating_mode_select,
  // outgoing timing pins
  input wire logic byte_clock,
  input wire logic nibble_clock,
  // upstream byte stream
  input wire logic up_valid,
  output logic up_ready,
  input wire logic [7:0] up_data,
  input wire logic up_alarm,
  input wire logic up_idle,
  input wire logic up_toh,
  input wire logic [3:0] up_poh_kind,
  input wire logic up_tu3,
  input wire logic [1:0] up_trib,
  input wire logic up_h4,
  input wire logic up_frame_start,
  // outgoing bus and indicators
  output logic [7:0] outgoing_data_bus,
  output logic alarm_indicator,
  output logic idle_indicator,
  output logic path_overhead_marker,
  output logic [3:1] multiframe_loss_flag,
  output logic underrun_pulse
);
  // pin synchroniser, bit 0 byte clock, bit 1 nibble clock
  logic [1:0] pin_in;
  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  logic [1:0] sync3_reg;
  logic [1:0] lvl_reg; // filtered pin level
  logic [1:0] agree;
  logic [1:0] rise;
  logic byte_rise;
  logic nib_rise;

  // buffer interface
  logic [oti_pkg::WORD_W-1:0] up_word;
  logic [oti_pkg::WORD_W-1:0] f_data;
  logic f_valid;
  logic f_ready;

  // fields of the word at the buffer head
  logic [7:0] w_data;
  logic w_alarm;
  logic w_idle;
  logic w_toh;
  logic [3:0] w_kind;
  logic w_tu3;
  logic [1:0] w_trib;
  logic w_h4;
  logic w_frame;

  // transfer control
  logic byte_mode;
  logic pop_req;
  logic pop;
  logic underrun;
  logic toh_gate;
  logic poh_tu3_hit;
  logic poh_vt_hit;
  logic poh_hit;

  // output state
  logic [7:0] bus_reg;
  logic [7:0] bus_next;
  logic [3:0] low_nib_reg; // second nibble waits here
  logic phase_reg; // high while low nibble is due
  logic alarm_reg;
  logic idle_reg;
  logic poh_reg;
  logic [2:0] lom_reg;
  logic [2:0] lost_rev;
  logic [oti_pkg::TRIB_N-1:0] lost;
  logic underrun_reg;

  // pins are asynchronous to clk_sys
  assign pin_in = {nibble_clock, byte_clock};
  // a level is accepted once stages two and three agree
  assign agree = ~(sync2_reg ^ sync3_reg);
  assign rise = agree & sync2_reg & ~lvl_reg;
  assign byte_rise = rise[0];
  assign nib_rise = rise[1];

  // three flop chain plus accepted level
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= 2'h0;
      sync2_reg <= 2'h0;
      sync3_reg <= 2'h0;
      lvl_reg <= 2'h0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      lvl_reg <= (agree & sync2_reg) | (~agree & lvl_reg);
    end
  end

  // pack one outgoing byte with its markers
  assign up_word = {up_frame_start, up_h4, up_trib, up_tu3,
                    up_poh_kind, up_toh, up_idle, up_alarm,
                    up_data};

  // the buffer absorbs upstream jitter against the pin clocks
  oti_fifo #(
    .WIDTH(oti_pkg::WORD_W),
    .DEPTH(oti_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .in_valid(up_valid),
    .in_ready(up_ready),
    .in_data(up_word),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // unpack the head word
  assign w_data = f_data[oti_pkg::F_DATA_LSB +: 8];
  assign w_alarm = f_data[oti_pkg::F_ALARM];
  assign w_idle = f_data[oti_pkg::F_IDLE];
  assign w_toh = f_data[oti_pkg::F_TOH];
  assign w_kind = f_data[oti_pkg::F_KIND_LSB +: 4];
  assign w_tu3 = f_data[oti_pkg::F_TU3];
  assign w_trib = f_data[oti_pkg::F_TRIB_LSB +: 2];
  assign w_h4 = f_data[oti_pkg::F_H4];
  assign w_frame = f_data[oti_pkg::F_FRAME];

  // one byte leaves per byte edge, or per nibble pair
  assign byte_mode = byte_interface_select;
  assign pop_req = byte_mode ? byte_rise // [R7]
                             : (nib_rise & ~phase_reg); // [R8]
  assign f_ready = pop_req;
  assign pop = pop_req & f_valid;
  // an empty buffer at a due edge sends a blank byte
  assign underrun = pop_req & ~f_valid;

  // locked mode blanks overhead; floating leaves it raw,
  // downstream must ignore those bytes itself
  assign toh_gate = ~floating_mode_select & w_toh; // [R4] [R14] [R3]

  // marker set depends on the tributary type
  assign poh_tu3_hit = (w_kind >= oti_pkg::POH_J1) &&
                       (w_kind <= oti_pkg::POH_Z5); // [R5]
  assign poh_vt_hit = (w_kind >= oti_pkg::POH_V5) &&
                      (w_kind <= oti_pkg::POH_Z7); // [R6]
  assign poh_hit = w_tu3 ? poh_tu3_hit : poh_vt_hit;

  // bus value for this edge
  always_comb begin
    bus_next = bus_reg;
    if (underrun) begin
      bus_next = oti_pkg::BUS_RST;
    end else if (pop && byte_mode) begin
      bus_next = w_data; // [R7]
    end else if (pop) begin
      // msb of the nibble on bit 3, high half first
      bus_next = {4'h0, w_data[7:4]}; // [R13]
    end else if (!byte_mode && nib_rise && phase_reg) begin
      bus_next = {4'h0, low_nib_reg}; // [R13] [R8]
    end
  end

  // bus, nibble phase and held low half
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bus_reg <= oti_pkg::BUS_RST;
      low_nib_reg <= 4'h0;
      phase_reg <= 1'b0;
    end else begin
      bus_reg <= bus_next;
      if (pop) begin
        low_nib_reg <= w_data[3:0];
      end
      if (byte_mode) begin
        phase_reg <= 1'b0;
      end else if (nib_rise) begin
        phase_reg <= phase_reg ? 1'b0 : f_valid;
      end
    end
  end

  // indicators hold for the whole byte, both nibbles
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      alarm_reg <= 1'b0;
      idle_reg <= 1'b0;
      poh_reg <= 1'b0;
    end else if (pop) begin
      alarm_reg <= w_alarm & ~toh_gate; // [R1] [R4]
      idle_reg <= w_idle & ~toh_gate; // [R2] [R4]
      poh_reg <= poh_hit & ~toh_gate; // [R5] [R6] [R4]
    end else if (underrun) begin
      alarm_reg <= 1'b0;
      idle_reg <= 1'b0;
      poh_reg <= 1'b0;
    end
  end

  // one multiframe tracker per tributary
  genvar g;
  generate
    for (g = 0; g < oti_pkg::TRIB_N; g++) begin : g_trib
      oti_mf_track u_track (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .frame_tick(pop & w_frame),
        .h4_strobe(pop & w_h4 & (w_trib == 2'(g))),
        .h4_phase(w_data[1:0]),
        .lost(lost[g])
      );
      // first tributary lands on the highest flag bit
      assign lost_rev[oti_pkg::TRIB_N-1-g] = lost[g]; // [R11]
    end
  endgenerate

  // loss flags follow the byte clock even in nibble mode,
  // so a change may lag the tracker by up to one byte
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lom_reg <= oti_pkg::LOM_RST;
      underrun_reg <= 1'b0;
    end else begin
      if (byte_rise) begin
        lom_reg <= lost_rev; // [R12] [R11]
      end
      underrun_reg <= underrun;
    end
  end

  // port drive
  assign outgoing_data_bus = bus_reg;
  assign alarm_indicator = alarm_reg;
  assign idle_indicator = idle_reg;
  assign path_overhead_marker = poh_reg;
  assign multiframe_loss_flag = lom_reg;
  assign underrun_pulse = underrun_reg;

  // a locked-mode overhead byte being sent
  sequence s_locked_toh_pop;
    pop && toh_gate;
  endsequence

  // a tu3 overhead byte being sent outside locked-mode overhead
  sequence s_tu3_poh_pop;
    pop && w_tu3 && poh_tu3_hit && !toh_gate;
  endsequence

  // a nibble pair: pop then the second nibble edge
  sequence s_nibble_pair;
    pop && !byte_mode ##1 (!nib_rise)[*1] ##[1:200] nib_rise;
  endsequence

  chk_alarm_follow: assert property ( // [R1]
    @(posedge clk_sys) disable iff (!rst_b)
    pop |=> alarm_indicator == $past(w_alarm & ~toh_gate))
    else $error("alarm indicator does not follow byte");

  chk_idle_follow: assert property ( // [R2]
    @(posedge clk_sys) disable iff (!rst_b)
    pop |=> idle_indicator == $past(w_idle & ~toh_gate))
    else $error("idle indicator does not follow byte");

  chk_locked_blank: assert property ( // [R4]
    @(posedge clk_sys) disable iff (!rst_b)
    s_locked_toh_pop |=> !alarm_indicator && !idle_indicator
      && !path_overhead_marker)
    else $error("indicator high on locked overhead");

  chk_poh_tu3: assert property ( // [R5]
    @(posedge clk_sys) disable iff (!rst_b)
    s_tu3_poh_pop |=> path_overhead_marker)
    else $error("tu3 overhead byte not marked");

  chk_poh_plain: assert property ( // [R6]
    @(posedge clk_sys) disable iff (!rst_b)
    pop && !w_tu3 && !poh_vt_hit |=> !path_overhead_marker)
    else $error("non tributary overhead byte marked");

  chk_byte_edge: assert property ( // [R7]
    @(posedge clk_sys) disable iff (!rst_b)
    byte_mode && $changed(outgoing_data_bus) |->
      $past(byte_rise))
    else $error("byte bus moved off byte edge");

  chk_nibble_upper: assert property ( // [R13]
    @(posedge clk_sys) disable iff (!rst_b)
    s_nibble_pair |=> outgoing_data_bus[7:4] == 4'h0)
    else $error("upper bus bits high in nibble mode");

  chk_nibble_edge: assert property ( // [R8]
    @(posedge clk_sys) disable iff (!rst_b)
    !byte_mode && $past(!byte_mode) &&
      $changed(outgoing_data_bus) |-> $past(nib_rise))
    else $error("nibble bus moved off nibble edge");

  chk_lom_edge: assert property ( // [R12]
    @(posedge clk_sys) disable iff (!rst_b)
    $changed(multiframe_loss_flag) |-> $past(byte_rise))
    else $error("loss flag moved off byte edge");

  chk_lom_order: assert property ( // [R11]
    @(posedge clk_sys) disable iff (!rst_b)
    byte_rise |=> multiframe_loss_flag[3] == $past(lost[0]))
    else $error("first tributary not on top flag");

  // an empty buffer at a due edge sends a blank byte
  chk_underrun_blank: assert property ( // [R1] [R2]
    @(posedge clk_sys) disable iff (!rst_b)
    underrun |=> (outgoing_data_bus == oti_pkg::BUS_RST) && underrun_pulse
      && !alarm_indicator && !idle_indicator && !path_overhead_marker)
    else $error("blank byte not sent on empty buffer");

  // second nibble of a pair: low half out, markers held
  sequence s_second_nibble;
    !byte_mode && nib_rise && phase_reg;
  endsequence

  chk_nibble_low: assert property ( // [R13]
    @(posedge clk_sys) disable iff (!rst_b)
    s_second_nibble |=> outgoing_data_bus == {4'h0, $past(low_nib_reg)})
    else $error("second nibble is not the held low half");

  chk_ind_hold: assert property ( // [R8]
    @(posedge clk_sys) disable iff (!rst_b)
    s_second_nibble |=> $stable(alarm_indicator) && $stable(idle_indicator)
      && $stable(path_overhead_marker))
    else $error("indicators moved inside a nibble pair");
endmodule // oti_out_ind

// ### dv/oti_sink_model.sv
`timescale 1ns/1ps
module oti_sink_model (
  // system
  input wire logic clk_sys,
  input wire logic rst_b,
  // pacing from the bench
  input wire logic run,
  input wire logic byte_mode,
  input wire logic [5:0] half,
  // pin clocks toward the block
  output logic byte_clock,
  output logic nibble_clock
);
  // half-period counter and the shared pin level
  logic [5:0] cnt_reg;
  logic pin_reg;

  // pin toggles every half cycles; once run drops it parks low, so the
  // block never sees a stray edge between bursts
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 6'h00;
      pin_reg <= 1'b0;
    end else if (!run && !pin_reg) begin
      cnt_reg <= 6'h00;
    end else if (cnt_reg + 6'h01 >= half) begin
      cnt_reg <= 6'h00;
      pin_reg <= ~pin_reg;
    end else begin
      cnt_reg <= cnt_reg + 6'h01;
    end
  end

  // only the clock of the selected interface mode moves
  assign byte_clock = pin_reg & byte_mode;
  assign nibble_clock = pin_reg & ~byte_mode;
endmodule // oti_sink_model

// ### dv/outgoing_tributary_indicators_tb_top.sv
`timescale 1ns/1ps
module outgoing_tributary_indicators_tb_top;
  // clock, reset and static configuration
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic byte_interface_select = 1'b1;
  logic floating_mode_select = 1'b0;
  // upstream word fields
  logic up_valid = 1'b0;
  logic [7:0] up_data = 8'h00;
  logic up_alarm = 1'b0;
  logic up_idle = 1'b0;
  logic up_toh = 1'b0;
  logic [3:0] up_poh_kind = 4'h0;
  logic up_tu3 = 1'b0;
  logic [1:0] up_trib = 2'h0;
  logic up_h4 = 1'b0;
  logic up_frame_start = 1'b0;
  // partner pacing
  logic run = 1'b0;
  logic [5:0] half = 6'h08;
  // observed outputs
  logic byte_clock, nibble_clock, up_ready, underrun_pulse;
  logic alarm_indicator, idle_indicator, path_overhead_marker;
  logic [7:0] outgoing_data_bus;
  logic [3:1] multiframe_loss_flag;
  // notes of expected bytes; bit 11 marks indicators as don't-care
  logic [11:0] exp_q[$];
  int fails = 0;
  int samples_checked = 0;
  logic [31:0] rng = 32'h0000_000e;
  logic under_seen = 1'b0;

  // 125 MHz system clock
  always #4 clk_sys = ~clk_sys;

  oti_out_ind dut_u (
    .clk_sys(clk_sys), .rst_b(rst_b),
    .byte_interface_select(byte_interface_select),
    .floating_mode_select(floating_mode_select),
    .byte_clock(byte_clock), .nibble_clock(nibble_clock),
    .up_valid(up_valid), .up_ready(up_ready), .up_data(up_data),
    .up_alarm(up_alarm), .up_idle(up_idle), .up_toh(up_toh),
    .up_poh_kind(up_poh_kind), .up_tu3(up_tu3), .up_trib(up_trib),
    .up_h4(up_h4), .up_frame_start(up_frame_start),
    .outgoing_data_bus(outgoing_data_bus),
    .alarm_indicator(alarm_indicator), .idle_indicator(idle_indicator),
    .path_overhead_marker(path_overhead_marker),
    .multiframe_loss_flag(multiframe_loss_flag),
    .underrun_pulse(underrun_pulse)
  );

  oti_sink_model sink_u (
    .clk_sys(clk_sys), .rst_b(rst_b), .run(run),
    .byte_mode(byte_interface_select), .half(half),
    .byte_clock(byte_clock), .nibble_clock(nibble_clock)
  );

  // single comparison point
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // closing report, reached from the main sequence or the watchdog
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // xorshift step for random words
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // fl = {alarm, idle, toh, tu3}, ev = {frame start, h4}; valid stays up
  task automatic push(input logic [7:0] d, input logic [3:0] fl,
      input logic [3:0] k, input logic [1:0] tr, input logic [1:0] ev);
    logic gate, mk, dc;
    logic [2:0] ind;
    int n;
    gate = !floating_mode_select && fl[1];
    dc = floating_mode_select && fl[1];
    mk = fl[0] ? (k >= 4'h1 && k <= 4'h9)
               : (k >= 4'ha && k <= 4'hd);
    ind = {fl[3], fl[2], mk} & {3{!gate}};
    if (byte_interface_select) exp_q.push_back({dc, d, ind});
    else begin
      exp_q.push_back({dc, 4'h0, d[7:4], ind});
      exp_q.push_back({dc, 4'h0, d[3:0], ind});
    end
    up_valid <= 1'b1;
    up_data <= d;
    {up_alarm, up_idle, up_toh, up_tu3} <= fl;
    up_poh_kind <= k;
    up_trib <= tr;
    {up_frame_start, up_h4} <= ev;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (up_ready !== 1'b1 && n < 100);
    if (n >= 100) fails++;
  endtask

  // drop valid and let one edge pass
  task automatic hold_off;
    up_valid <= 1'b0;
    @(posedge clk_sys);
  endtask

  // run the pin clock until every note is consumed, plus idle edges
  task automatic burst(input logic [5:0] h);
    int n;
    half <= h;
    run <= 1'b1;
    n = 0;
    while (exp_q.size() != 0 && n < 5000) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (8 * h) @(posedge clk_sys);
    run <= 1'b0;
    repeat (4 * h) @(posedge clk_sys);
    if (n >= 5000) fails++;
  endtask

  // watcher: each pin rise produces one settled byte or nibble
  always @(posedge byte_clock or posedge nibble_clock) begin
    logic [11:0] e;
    repeat (7) @(posedge clk_sys);
    @(negedge clk_sys);
    e = (exp_q.size() != 0) ? exp_q.pop_front() : 12'h000;
    if (e[11]) check({outgoing_data_bus, 3'b000}, {e[10:3], 3'b000});
    else check({outgoing_data_bus, alarm_indicator, idle_indicator,
        path_overhead_marker}, e[10:0]);
  end

  // remembers that an empty-buffer pop was flagged
  always @(posedge clk_sys) if (underrun_pulse === 1'b1) under_seen <= 1'b1;

  // watchdog, generous against the few thousand cycles expected
  initial begin
    repeat (40000) @(posedge clk_sys);
    fails++;
    print_verdict;
  end

  // main sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    check(11'({multiframe_loss_flag, up_ready}), 11'h00f);
    // locked byte mode, random words, buffer filled until it refuses
    for (int i = 0; i < 16; i++) begin
      rng = xs(rng);
      push(rng[7:0], rng[11:8], rng[15:12], 2'h0, 2'h0);
    end
    hold_off;
    check(11'(up_ready), 11'h000);
    burst(6'h05);
    check(11'(under_seen), 11'h001);
    // floating byte mode, every overhead kind with and without tu3, slow;
    // kinds 14 and 15 go out as transport overhead, markers don't-care
    floating_mode_select <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 32; i++) begin
      push(8'(i * 7), {2'(i), &i[3:1], i[4]}, i[3:0], 2'h1, 2'h0);
      if (i % 16 == 15) begin
        hold_off;
        burst(6'h14);
      end
    end
    // locked nibble mode, random words
    floating_mode_select <= 1'b0;
    byte_interface_select <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 16; i++) begin
      rng = xs(rng);
      push(rng[7:0], rng[11:8], rng[15:12], 2'h2, 2'h0);
    end
    hold_off;
    burst(6'h08);
    // multiframe acquisition and loss for each tributary
    byte_interface_select <= 1'b1;
    @(posedge clk_sys);
    for (int t = 0; t < 3; t++) begin
      for (int p = 0; p < 4; p++) push(8'(p), 4'h0, 4'h6, 2'(t), 2'h3);
      push(8'h00, 4'h0, 4'h0, 2'(t), 2'h0);
      push(8'h00, 4'h0, 4'h0, 2'(t), 2'h0);
      hold_off;
      burst(6'h05);
      check(11'(multiframe_loss_flag), 11'(3'h7 ^ (3'h4 >> t)));
      for (int f = 0; f < 8; f++) begin
        push(8'h00, 4'h0, 4'h0, 2'(t), 2'h2);
        if (f >= 6) begin
          push(8'h00, 4'h0, 4'h0, 2'(t), 2'h0);
          push(8'h00, 4'h0, 4'h0, 2'(t), 2'h0);
          hold_off;
          burst(6'h05);
        end
      end
      check(11'(multiframe_loss_flag), 11'h007);
    end
    print_verdict;
  end
endmodule // outgoing_tributary_indicators_tb_top
